// file: hw/pixel_out_pkg.sv
// package with constants, carriers and states of the dual pixel output port
package pixel_out_pkg;

   // ------------------------------------------------------------
   // widths and depths
   // ------------------------------------------------------------
   localparam int pixel_width = 24;
   localparam int fifo_depth = 16;
   localparam int fifo_addr_width = 4;

   // ------------------------------------------------------------
   // register map (word aligned byte addresses)
   // ------------------------------------------------------------
   localparam logic [3:0] ctrl_offset = 4'h0;
   localparam logic [3:0] status_offset = 4'h4;
   localparam logic [3:0] pixel_offset = 4'h8;
   localparam logic [3:0] frame_offset = 4'hc;

   // control register field positions
   localparam int ctrl_power_up_bit = 0;
   localparam int ctrl_output_enable_bit = 1;
   localparam int ctrl_two_pixel_bit = 2;
   localparam int ctrl_invert_bit = 3;
   localparam logic [3:0] ctrl_reset_value = 4'h0;

   // pixel write word: bit 24 is the active video flag
   localparam int pixel_active_bit = 24;

   // answer for an unmapped read
   localparam logic [31:0] unmapped_read_value = 32'h0000_0000;

   // ------------------------------------------------------------
   // carriers and states
   // ------------------------------------------------------------
   typedef struct packed {
      logic active;
      logic [23:0] pixel;
   } pixel_word_type;

   typedef struct packed {
      logic [23:0] even_pixel;
      logic [23:0] odd_pixel;
      logic active;
   } out_beat_type;

   typedef enum logic [0:0] {pair_first, pair_second} pair_state_type;

endpackage

// file: hw/pixel_fifo.sv
// parameterised valid/ready fifo holding pixel words
`timescale 1ns/1ps
module pixel_fifo #(
   parameter int width = 25,
   parameter int depth = 16,
   parameter int addr_width = 4
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [width-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [width-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);

   logic [width-1:0] mem [depth];
   logic [addr_width-1:0] wr_ptr_reg, wr_ptr_next;
   logic [addr_width-1:0] rd_ptr_reg, rd_ptr_next;
   logic [addr_width:0] count_reg, count_next;
   logic push, pop;

   // ------------------------------------------------------------
   // pointer and count
   // ------------------------------------------------------------
   always_comb begin
      in_ready = (count_reg != (addr_width+1)'(depth)) ? 1'b1 : 1'b0;
      out_valid = (count_reg != '0);
      out_data = mem[rd_ptr_reg];
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      wr_ptr_next = push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
      rd_ptr_next = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
      count_next = count_reg;
      if (push && !pop) begin
         count_next = count_reg + 1'b1;
      end else if (pop && !push) begin
         count_next = count_reg - 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end else begin
         wr_ptr_reg <= wr_ptr_next;
         rd_ptr_reg <= rd_ptr_next;
         count_reg <= count_next;
      end
   end

   // storage array, written on accepted push
   always_ff @(posedge clock) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data;
      end
   end

endmodule

// file: hw/dual_pixel_output_port.sv
// dual pixel video output port with avalon register access
//
// Chosen here: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
// What this block does
// - one pixel per clock mode shows each whole pixel on the even bus.
// - two pixel mode puts the first pixel of a pair on the even bus.
// - two pixel mode puts the second pixel of a pair on the odd bus.
// - one pixel per clock mode holds the odd bus all low.
// - both buses change only on the output pixel clock.
// - power down or output disable low sets all pixel drivers off.
// - while drivers are off a weak pull down takes each output low.
// - inversion 0 means the panel captures on the falling clock edge.
// - inversion 1 means the panel captures on the rising clock edge.
// - active video flag high in display time, low in blanking, aligned with data.
// - the output clock is inverted under the clock inversion control.
module dual_pixel_output_port (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic power_down_n,
   input wire logic output_disable_n,
   output logic [23:0] even_pixel_bus,
   output logic [23:0] even_pixel_oe,
   output logic [23:0] odd_pixel_bus,
   output logic [23:0] odd_pixel_oe,
   output logic active_video_flag,
   output logic active_video_oe,
   output logic pixel_out_clock,
   output logic pixel_out_clock_oe
);

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   logic [3:0] ctrl_reg, ctrl_next;
   logic [31:0] ctrl_merged;
   logic [31:0] readdata_reg, readdata_next;
   logic waitrequest_reg, waitrequest_next;
   logic [31:0] frame_count_reg, frame_count_next;
   logic fifo_in_valid;
   logic fifo_in_ready;
   pixel_out_pkg::pixel_word_type fifo_in_word;
   pixel_out_pkg::pixel_word_type fifo_out_word;
   logic fifo_out_valid;
   logic fifo_out_ready;
   pixel_out_pkg::pair_state_type pair_reg, pair_next;
   logic [23:0] first_pixel_reg, first_pixel_next;
   pixel_out_pkg::out_beat_type beat_reg, beat_next;
   logic clock_phase_reg, clock_phase_next;
   logic drive_reg, drive_next;
   logic two_pixel;
   logic invert;
   logic enabled;
   logic access;
   logic pixel_hit;

   // merge byte lanes into an old word
   function automatic logic [31:0] merge_bytes(input logic [31:0] old_word,
                                               input logic [31:0] new_word,
                                               input logic [3:0] lanes);
      logic [31:0] result;
      result = old_word;
      for (int i = 0; i < 4; i++) begin
         if (lanes[i]) begin
            result[i*8 +: 8] = new_word[i*8 +: 8];
         end
      end
      return result;
   endfunction

   // ------------------------------------------------------------
   // register bus slave
   // ------------------------------------------------------------
   // a request is answered one cycle after it appears; a pixel write
   // stays stalled while the fifo is full so the source is held back
   always_comb begin
      access = (avs_read || avs_write) && waitrequest_reg;
      pixel_hit = avs_write && (avs_address == pixel_out_pkg::pixel_offset);
      ctrl_merged = merge_bytes({28'h0000000, ctrl_reg}, avs_writedata, avs_byteenable);
      ctrl_next = ctrl_reg;
      readdata_next = readdata_reg;
      waitrequest_next = 1'b1;
      fifo_in_valid = 1'b0;
      fifo_in_word.active = avs_writedata[pixel_out_pkg::pixel_active_bit];
      fifo_in_word.pixel = avs_writedata[23:0];
      if (access) begin
         if (pixel_hit) begin
            fifo_in_valid = 1'b1;
            waitrequest_next = !fifo_in_ready;
         end else begin
            waitrequest_next = 1'b0;
            if (avs_write && avs_address == pixel_out_pkg::ctrl_offset) begin
               ctrl_next = ctrl_merged[3:0];
            end
            if (avs_read) begin
               case (avs_address)
                  pixel_out_pkg::ctrl_offset: readdata_next = {28'h0000000, ctrl_reg};
                  pixel_out_pkg::status_offset: readdata_next = {27'h0000000, drive_reg,
                     fifo_out_valid, !fifo_in_ready, pair_reg == pixel_out_pkg::pair_second,
                     beat_reg.active};
                  pixel_out_pkg::frame_offset: readdata_next = frame_count_reg;
                  default: readdata_next = pixel_out_pkg::unmapped_read_value;
               endcase
            end
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ctrl_reg <= pixel_out_pkg::ctrl_reset_value;
         readdata_reg <= 32'h00000000;
         waitrequest_reg <= 1'b1;
      end else begin
         ctrl_reg <= ctrl_next;
         readdata_reg <= readdata_next;
         waitrequest_reg <= waitrequest_next;
      end
   end

   assign avs_readdata = readdata_reg;
   assign avs_waitrequest = waitrequest_reg;

   // ------------------------------------------------------------
   // pixel fifo
   // ------------------------------------------------------------
   pixel_fifo #(
      .width(pixel_out_pkg::pixel_width + 1),
      .depth(pixel_out_pkg::fifo_depth),
      .addr_width(pixel_out_pkg::fifo_addr_width)
   ) u_fifo (
      .clock(clock),
      .rst_n(rst_n),
      .in_data(fifo_in_word),
      .in_valid(fifo_in_valid),
      .in_ready(fifo_in_ready),
      .out_data(fifo_out_word),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready)
   );

   // ------------------------------------------------------------
   // pixel output clock and beat sequencing
   // ------------------------------------------------------------
   // the output clock runs at half the system clock; data changes on the
   // system edge where the output clock leaves its capture level
   always_comb begin
      two_pixel = ctrl_reg[pixel_out_pkg::ctrl_two_pixel_bit];
      invert = ctrl_reg[pixel_out_pkg::ctrl_invert_bit];
      enabled = power_down_n && output_disable_n && ctrl_reg[pixel_out_pkg::ctrl_power_up_bit]
         && ctrl_reg[pixel_out_pkg::ctrl_output_enable_bit];
      clock_phase_next = !clock_phase_reg;
      drive_next = enabled;
      fifo_out_ready = 1'b0;
      pair_next = pair_reg;
      first_pixel_next = first_pixel_reg;
      beat_next = beat_reg;
      frame_count_next = frame_count_reg;
      // nothing is consumed while the drivers are off, so pixels written
      // during power down wait in the fifo instead of being lost
      if (drive_reg && clock_phase_reg) begin
         if (!fifo_out_valid || (two_pixel && pair_reg == pixel_out_pkg::pair_first)) begin
            // underrun, or no first half loaded yet, counts as blanking
            beat_next.active = 1'b0;
         end else if (!two_pixel) begin
            fifo_out_ready = 1'b1;                           // one pixel per output period
            beat_next.even_pixel = fifo_out_word.pixel;
            beat_next.odd_pixel = 24'h000000;
            beat_next.active = fifo_out_word.active;
            pair_next = pixel_out_pkg::pair_first;
         end else begin
            fifo_out_ready = 1'b1;                           // second half closes the pair
            beat_next.even_pixel = first_pixel_reg;
            beat_next.odd_pixel = fifo_out_word.pixel;
            beat_next.active = fifo_out_word.active;
            pair_next = pixel_out_pkg::pair_first;
         end
         if (beat_reg.active && !beat_next.active) begin
            frame_count_next = frame_count_reg + 32'h00000001;
         end
      end else if (drive_reg && two_pixel && pair_reg == pixel_out_pkg::pair_first && fifo_out_valid) begin
         // two pixel mode takes the first half of a pair in the other half
         // period, so each output period carries one whole pair
         fifo_out_ready = 1'b1;
         first_pixel_next = fifo_out_word.pixel;
         pair_next = pixel_out_pkg::pair_second;
      end
      if (!two_pixel) begin
         beat_next.odd_pixel = 24'h000000;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         clock_phase_reg <= 1'b0;
         drive_reg <= 1'b0;
         pair_reg <= pixel_out_pkg::pair_first;
         first_pixel_reg <= 24'h000000;
         beat_reg <= '0;
         frame_count_reg <= 32'h00000000;
      end else begin
         clock_phase_reg <= clock_phase_next;
         drive_reg <= drive_next;
         pair_reg <= pair_next;
         first_pixel_reg <= first_pixel_next;
         beat_reg <= beat_next;
         frame_count_reg <= frame_count_next;
      end
   end

   // ------------------------------------------------------------
   // output pins
   // ------------------------------------------------------------
   // the clock takes clock_phase_reg ^ invert on the edge that launches new data, so
   // with no inversion it is high then and falls mid-data
   // inverted it rises mid-data
   logic [23:0] even_out_reg, odd_out_reg;
   logic active_out_reg, clock_out_reg;
   logic [23:0] even_out_next, odd_out_next;
   logic active_out_next, clock_out_next;

   // disabled pins are not driven and read low through the pull down
   always_comb begin
      even_out_next = drive_next ? beat_next.even_pixel : 24'h000000;
      odd_out_next = drive_next ? beat_next.odd_pixel : 24'h000000;
      active_out_next = drive_next ? beat_next.active : 1'b0;
      clock_out_next = drive_next ? (clock_phase_reg ^ invert) : 1'b0;
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         even_out_reg <= 24'h000000;
         odd_out_reg <= 24'h000000;
         active_out_reg <= 1'b0;
         clock_out_reg <= 1'b0;
      end else begin
         even_out_reg <= even_out_next;
         odd_out_reg <= odd_out_next;
         active_out_reg <= active_out_next;
         clock_out_reg <= clock_out_next;
      end
   end

   assign even_pixel_bus = even_out_reg;
   assign odd_pixel_bus = odd_out_reg;
   assign active_video_flag = active_out_reg;
   assign pixel_out_clock = clock_out_reg;
   assign even_pixel_oe = {24{drive_reg}};
   assign odd_pixel_oe = {24{drive_reg}};
   assign active_video_oe = drive_reg;
   assign pixel_out_clock_oe = drive_reg;

endmodule

// file: bench/panel_capture_model.sv
// panel timing controller model that captures beats on the active output clock edge
`timescale 1ns/1ps
module panel_capture_model (
   input wire logic out_clock_invert,
   input wire logic [23:0] even_pixel_bus,
   input wire logic [23:0] even_pixel_oe,
   input wire logic [23:0] odd_pixel_bus,
   input wire logic [23:0] odd_pixel_oe,
   input wire logic active_video_flag,
   input wire logic active_video_oe,
   input wire logic pixel_out_clock,
   input wire logic pixel_out_clock_oe
);
   // ------------------------------------------------------------
   // wire levels with the weak pull-down when a driver is off
   // ------------------------------------------------------------
   logic [23:0] even_wire;
   logic [23:0] odd_wire;
   logic flag_wire;
   logic clock_wire;
   pixel_out_pkg::out_beat_type cap_q[$];
   assign even_wire = even_pixel_bus & even_pixel_oe;
   assign odd_wire = odd_pixel_bus & odd_pixel_oe;
   assign flag_wire = active_video_flag & active_video_oe;
   assign clock_wire = pixel_out_clock & pixel_out_clock_oe;

   // capture on falling edge when not inverted, rising edge when inverted
   always @(posedge clock_wire or negedge clock_wire) begin
      if (clock_wire == out_clock_invert && flag_wire === 1'b1) begin
         cap_q.push_back(pixel_out_pkg::out_beat_type'({even_wire, odd_wire, flag_wire}));
      end
   end
endmodule

// file: bench/dual_pixel_output_port_checker.sv
// concurrent assertions on the ports of the dual pixel output port
`timescale 1ns/1ps
module dual_pixel_output_port_checker (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic avs_waitrequest,
   input wire logic power_down_n,
   input wire logic output_disable_n,
   input wire logic [23:0] even_pixel_bus,
   input wire logic [23:0] even_pixel_oe,
   input wire logic [23:0] odd_pixel_bus,
   input wire logic [23:0] odd_pixel_oe,
   input wire logic active_video_flag,
   input wire logic active_video_oe,
   input wire logic pixel_out_clock,
   input wire logic pixel_out_clock_oe
);
   // ------------------------------------------------------------
   // mirror of the control register as written on the bus
   // ------------------------------------------------------------
   logic [3:0] ctrl_reg;
   logic [3:0] ctrl_next;
   logic pins_off;
   assign pins_off = !(power_down_n && output_disable_n);
   always_comb begin
      ctrl_next = ctrl_reg;
      if (avs_write && !avs_waitrequest && avs_address == pixel_out_pkg::ctrl_offset && avs_byteenable[0]) begin
         ctrl_next = avs_writedata[3:0];
      end
   end
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ctrl_reg <= 4'h0;
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end

   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);

   a_off_when_pin_low: assert property (pins_off ##1 pins_off |-> !pixel_out_clock_oe && !active_video_oe
      && even_pixel_oe == 24'h0 && odd_pixel_oe == 24'h0) else $error("drivers on with a pin low");
   a_oe_needs_pins: assert property (pixel_out_clock_oe |-> $past(power_down_n) && $past(output_disable_n))
      else $error("clock driven without both pins high");
   a_off_reads_low: assert property (even_pixel_bus == (even_pixel_bus & even_pixel_oe)
      && odd_pixel_bus == (odd_pixel_bus & odd_pixel_oe)) else $error("undriven pixel bit not low");
   a_off_flag_low: assert property ((!active_video_flag || active_video_oe) && (!pixel_out_clock || pixel_out_clock_oe))
      else $error("undriven flag or clock not low");
   a_odd_low_single: assert property (!ctrl_reg[2] |-> odd_pixel_bus == 24'h0)
      else $error("odd bus not low in one pixel mode");
   a_change_on_launch: assert property (pixel_out_clock_oe && $past(pixel_out_clock_oe) && $changed(even_pixel_bus)
      |-> pixel_out_clock == !ctrl_reg[3]) else $error("data changed at capture edge");
   a_data_holds_period: assert property (pixel_out_clock_oe && $past(pixel_out_clock_oe) && $changed(odd_pixel_bus)
      |=> $stable(odd_pixel_bus) || !pixel_out_clock_oe) else $error("odd data held under one period");
   a_flag_aligned: assert property (pixel_out_clock_oe && $past(pixel_out_clock_oe) && $changed(active_video_flag)
      |-> pixel_out_clock == !ctrl_reg[3]) else $error("flag not aligned with data");
   a_clock_toggles: assert property (pixel_out_clock_oe && $past(pixel_out_clock_oe)
      |-> pixel_out_clock != $past(pixel_out_clock)) else $error("output clock stopped");
   a_answer_single: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("answer longer than one cycle");
   a_read_answer: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest) else $error("read answer late");

   c_two_pixel: cover property (ctrl_reg[2] && active_video_flag);
   c_inverted: cover property (ctrl_reg[3] && pixel_out_clock_oe && $changed(even_pixel_bus));
   c_pixel_write: cover property (avs_write && !avs_waitrequest && avs_address == pixel_out_pkg::pixel_offset);
endmodule

bind dual_pixel_output_port dual_pixel_output_port_checker checker_u (.clock, .rst_n, .avs_address, .avs_read,
   .avs_write, .avs_writedata, .avs_byteenable, .avs_waitrequest, .power_down_n, .output_disable_n, .even_pixel_bus,
   .even_pixel_oe, .odd_pixel_bus, .odd_pixel_oe, .active_video_flag, .active_video_oe, .pixel_out_clock,
   .pixel_out_clock_oe);

// file: bench/test_dual_pixel_output_port.sv
// self-checking testbench of the dual pixel output port
`timescale 1ns/1ps
module test_dual_pixel_output_port;
   // ------------------------------------------------------------
   // signals, design, panel model
   // ------------------------------------------------------------
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'hf;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic power_down_n = 1'b0;
   logic output_disable_n = 1'b1;
   logic panel_invert = 1'b0;
   logic [23:0] even_pixel_bus, even_pixel_oe, odd_pixel_bus, odd_pixel_oe;
   logic active_video_flag, active_video_oe, pixel_out_clock, pixel_out_clock_oe;
   logic [31:0] r;
   int n_errors = 0;
   int n_compared = 0;
   int cycles = 0;

   dual_pixel_output_port dut_u (.clock, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest, .power_down_n, .output_disable_n, .even_pixel_bus,
      .even_pixel_oe, .odd_pixel_bus, .odd_pixel_oe, .active_video_flag, .active_video_oe, .pixel_out_clock,
      .pixel_out_clock_oe);
   panel_capture_model panel_u (.out_clock_invert(panel_invert), .even_pixel_bus, .even_pixel_oe, .odd_pixel_bus,
      .odd_pixel_oe, .active_video_flag, .active_video_oe, .pixel_out_clock, .pixel_out_clock_oe);

   // clock and cycle watchdog
   always #50 clock = ~clock;
   always @(posedge clock) begin
      cycles++;
      if (cycles == 3000) begin
         n_errors++;
         report_and_stop();
      end
   end

   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   function automatic logic [23:0] pix(input int i);
      return 24'h5a_0000 + 24'(i) * 24'h01_0203;
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] expected, input string what);
      n_compared++;
      if (seen !== expected) begin
         n_errors++;
         $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, expected);
      end
   endtask

   // one avalon access; holds the request until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [3:0] addr, input logic [31:0] wdata, output logic [31:0] rdata);
      avs_address <= addr;
      avs_writedata <= wdata;
      avs_write <= wr;
      avs_read <= !wr;
      do @(posedge clock); while (avs_waitrequest !== 1'b0);
      rdata = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clock);
   endtask

   task automatic wait_captures(input int n);
      while (panel_u.cap_q.size() < n) @(posedge clock);
      repeat (2) @(posedge clock);
   endtask

   task automatic report_and_stop;
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (20) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      bus(1'b0, pixel_out_pkg::ctrl_offset, 32'h0, r);
      check(r, 32'h0, "ctrl reset value");
      // fill the buffer while powered down: one-pixel mode, capture on falling edge
      bus(1'b1, pixel_out_pkg::ctrl_offset, 32'h3, r);
      for (int i = 0; i < 16; i++) begin
         bus(1'b1, pixel_out_pkg::pixel_offset, {7'h0, i != 15, pix(i)}, r);
      end
      bus(1'b0, pixel_out_pkg::status_offset, 32'h0, r);
      check(32'(r[3:2]), 32'h3, "buffer not full");
      check(32'(even_pixel_oe), 32'h0, "even drivers on while powered down");
      check(32'({pixel_out_clock_oe, active_video_oe}), 32'h0, "clock or flag driven");
      check(32'(even_pixel_bus), 32'h0, "even bus not pulled low");
      bus(1'b1, 4'h1, 32'hf, r);
      bus(1'b0, 4'h1, 32'h0, r);
      check(r, pixel_out_pkg::unmapped_read_value, "unmapped read");
      bus(1'b0, pixel_out_pkg::ctrl_offset, 32'h0, r);
      check(r, 32'h3, "ctrl changed by unmapped write");
      bus(1'b0, pixel_out_pkg::pixel_offset, 32'h0, r);
      check(r, 32'h0, "pixel register readable");
      // drain through the panel
      power_down_n <= 1'b1;
      wait_captures(15);
      check(32'(panel_u.cap_q.size()), 32'd15, "active beat count");
      for (int i = 0; i < 15; i++) begin
         check(32'(panel_u.cap_q[i].even_pixel), 32'(pix(i)), "even pixel one-pixel mode");
         check(32'(panel_u.cap_q[i].odd_pixel), 32'h0, "odd bus not low");
      end
      bus(1'b0, pixel_out_pkg::status_offset, 32'h0, r);
      check(32'({r[3], r[0]}), 32'h0, "buffer empty and blanking");
      bus(1'b0, pixel_out_pkg::frame_offset, 32'h0, r);
      check(r, 32'h1, "frame count");
      // two-pixel mode with capture on rising edge
      output_disable_n <= 1'b0;
      panel_invert <= 1'b1;
      panel_u.cap_q.delete();
      bus(1'b1, pixel_out_pkg::ctrl_offset, 32'hf, r);
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, pixel_out_pkg::pixel_offset, {7'h0, 1'b1, pix(20 + i)}, r);
      end
      output_disable_n <= 1'b1;
      wait_captures(2);
      for (int k = 0; k < 2; k++) begin
         check(32'(panel_u.cap_q[k].even_pixel), 32'(pix(20 + 2 * k)), "first pixel of pair");
         check(32'(panel_u.cap_q[k].odd_pixel), 32'(pix(21 + 2 * k)), "second pixel of pair");
      end
      report_and_stop();
   end
endmodule
